// file: hdl/pin_sync.sv
// Two flip-flop synchroniser for a vector of asynchronous pin inputs.
// Assumes a synchronous active-high reset on the sampling clock.
module pin_sync #(
   parameter int          W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk_i,  // Sampling clock
   input  wire logic         rst_i,  // Synchronous reset
   input  wire logic [W-1:0] d_i,    // Asynchronous inputs
   output logic      [W-1:0] q_o     // Synchronised outputs
);

   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   // Reset to open-pin levels so the logic sees defaults at start
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_r <= RST_VAL;
         q_r    <= RST_VAL;
      end else begin
         meta_r <= d_i;
         q_r    <= meta_r;
      end
   end

   assign q_o = q_r;

endmodule : pin_sync

// file: hdl/predriver_mode_and_spi_command_ctrl.sv
// Mode control and 8-bit serial command decoder of a three-phase predriver.
// Assumes all pin and comparator inputs are asynchronous to clk_i.
module predriver_mode_and_spi_command_ctrl (
   input  wire logic       clk_i,                  // 125 MHz clock
   input  wire logic       rst_i,                  // Sync reset, high
   input  wire logic       rst_pin_n_i,            // Global reset pin
   input  wire logic       enable_in_a_i,          // Enable pin a
   input  wire logic       enable_in_b_i,          // Enable pin b
   input  wire logic [2:0] phase_low_side_in_i,    // Low-side commands
   input  wire logic [2:0] phase_high_side_in_n_i, // High-side, low on
   input  wire logic       cs_n_i,                 // Chip select
   input  wire logic       sclk_i,                 // Serial clock
   input  wire logic       si_i,                   // Serial data in
   input  wire logic       overtemp_i,             // Overtemperature
   input  wire logic       desat_i,                // Desaturation
   input  wire logic       gate_supply_uv_i,       // Gate supply low
   input  wire logic       overcurrent_i,          // Overcurrent
   input  wire logic       phase_err_i,            // Phase comparator
   output logic     [2:0]  hs_gate_o,              // High-side drive on
   output logic     [2:0]  ls_gate_o,              // Low-side drive on
   output logic            hold_off_o,             // Weak pull-down on
   output logic            int_o,                  // Interrupt
   output logic            so_o,                   // Serial data out
   output logic            so_oe_o,                // SO drive enable
   output logic     [2:0]  mode_o,                 // Current mode
   output logic            full_conduction_mode_o, // Full-on mode
   output logic            desat_ignore_o,         // No desat shutdown
   output logic            deadtime_cal_o,         // Calibration start
   output logic     [4:0]  deadtime_code_o         // Deadtime data
);

   logic [predrv_pkg::PIN_W-1:0] pins_s;
   predrv_pkg::mode_t state_r;
   predrv_pkg::mode_t state_nxt;
   logic [7:0] latch_r;
   logic [7:0] snap_r;
   logic [7:0] mask_r;
   logic [3:0] mode_r;
   logic [4:0] dt_r;
   logic [1:0] sel_r;
   logic [2:0] ls_q_r;
   logic [2:0] hs_q_r;
   logic [2:0] boot_r;
   logic       ls_seen_r;
   logic       both_q_r;
   logic [2:0] hs_gate_r;
   logic [2:0] ls_gate_r;
   logic       hold_r;
   logic       int_r;
   logic       so_oe_r;
   logic       dt_cal_r;
   logic       start;
   logic       done;
   logic       ferr;
   logic [7:0] word;
   logic       so_bit;

   // Open-pin defaults are the synchroniser reset values
   pin_sync #(
      .W       (predrv_pkg::PIN_W),
      .RST_VAL (predrv_pkg::PIN_RST)
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({phase_err_i, overcurrent_i, gate_supply_uv_i, desat_i,
               overtemp_i, si_i, sclk_i, cs_n_i,
               phase_high_side_in_n_i, phase_low_side_in_i,
               enable_in_b_i, enable_in_a_i, rst_pin_n_i}),
      .q_o   (pins_s)
   );

   wire       rst_pin_s = pins_s[0];
   wire       both_en   = pins_s[1] & pins_s[2];
   wire [2:0] ls_s      = pins_s[5:3];
   wire [2:0] hs_n_s    = pins_s[8:6];
   wire       cs_n_s    = pins_s[9];
   wire       sclk_s    = pins_s[10];
   wire       si_s      = pins_s[11];
   wire [4:0] flt_s     = pins_s[16:12];
   wire       asleep    = ~rst_pin_s | rst_i;

   // Status words for the reply multiplexer
   wire [7:0] stat1 = {1'b0, state_r, mode_r};
   wire [7:0] stat3 = {3'h0, dt_r};
   wire [7:0] reply = (sel_r == 2'h1) ? stat1 :
                      (sel_r == 2'h2) ? mask_r :
                      (sel_r == 2'h3) ? stat3 : latch_r;

   spi_shift u_spi (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .en_i    (rst_pin_s),
      .cs_n_i  (cs_n_s),
      .sclk_i  (sclk_s),
      .si_i    (si_s),
      .reply_i (reply),
      .start_o (start),
      .done_o  (done),
      .ferr_o  (ferr),
      .word_o  (word),
      .so_o    (so_bit)
   );

   // Command decode
   wire [2:0] cmd      = word[7:predrv_pkg::CMD_LSB];
   wire       grp_b    = word[predrv_pkg::GRP_BIT];
   wire [3:0] nib      = word[3:0];
   wire       valid    = done & ~ferr;
   wire       is_null  = valid & (cmd == predrv_pkg::CMD_NULL);
   wire       is_mask  = valid & (cmd == predrv_pkg::CMD_MASK);
   wire       is_mode  = valid & (cmd == predrv_pkg::CMD_MODE);
   wire       is_clear = valid & (cmd == predrv_pkg::CMD_CLEAR);
   wire       is_dead  = valid & (cmd == predrv_pkg::CMD_DEAD);
   wire       locked   = mode_r[predrv_pkg::MODE_LOCK];
   wire       full_on  = mode_r[predrv_pkg::MODE_FULL_CONDUCTION_MODE];
   wire       desat_ig = mode_r[predrv_pkg::MODE_DESAT];
   wire       wlock    = is_mode & locked;

   // Fault sources; phase error is blanked in full-on mode
   wire phase_f  = flt_s[4] & ~full_on;
   wire prot_flt = flt_s[2] | ((flt_s[1] | phase_f) & ~desat_ig);
   wire rst_evt  = (state_r == predrv_pkg::ST_SLEEP & ~asleep) |
                   (both_q_r & ~both_en);
   wire [7:0] set_vec = {rst_evt, wlock, done & ferr, phase_f,
                         flt_s[3], flt_s[2], flt_s[1], flt_s[0]};
   // Only bits already set when the message began may be cleared
   wire [7:0] clr_vec = is_clear ?
                        ((grp_b ? {nib, 4'h0} : {4'h0, nib}) & snap_r)
                        : 8'h00;
   wire [7:0] latch_nxt = (latch_r & ~clr_vec) | set_vec;

   wire [2:0] ls_tog  = ls_q_r ^ ls_s;
   wire [2:0] hs_tog  = hs_q_r ^ hs_n_s;
   wire [2:0] ls_fall = ls_q_r & ~ls_s;
   wire       run     = (state_r == predrv_pkg::ST_INIT) |
                        (state_r == predrv_pkg::ST_ENABLE);

   always_comb begin
      state_nxt = state_r;
      if (asleep) begin
         state_nxt = predrv_pkg::ST_SLEEP;
      end else if (!both_en) begin
         state_nxt = predrv_pkg::ST_STANDBY;
      end else begin
         case (state_r)
            predrv_pkg::ST_SLEEP,
            predrv_pkg::ST_STANDBY: begin
               state_nxt = predrv_pkg::ST_INIT;
            end
            predrv_pkg::ST_INIT: begin
               if (prot_flt) begin
                  state_nxt = predrv_pkg::ST_FAULT;
               end else if (ls_seen_r && |hs_tog) begin
                  state_nxt = predrv_pkg::ST_ENABLE;
               end
            end
            predrv_pkg::ST_ENABLE: begin
               if (prot_flt) begin
                  state_nxt = predrv_pkg::ST_FAULT;
               end
            end
            predrv_pkg::ST_FAULT: begin
               if (!prot_flt) begin
                  state_nxt = predrv_pkg::ST_INIT;
               end
            end
            default: begin
               state_nxt = predrv_pkg::ST_SLEEP;
            end
         endcase
      end
   end

   // Gate drive selection per mode
   wire [2:0] hs_req  = ~hs_n_s & boot_r & (ls_s & {3{full_on}} | ~ls_s);
   wire [2:0] ls_nxt  = run ? ls_s : 3'h0;
   wire [2:0] hs_nxt  = (state_r == predrv_pkg::ST_ENABLE) ?
                        hs_req : 3'h0;

   always_ff @(posedge clk_i) begin
      if (asleep) begin
         // Sleep wipes every latch and serially written register
         state_r   <= predrv_pkg::ST_SLEEP;
         latch_r   <= predrv_pkg::LATCH_RST;
         snap_r    <= predrv_pkg::LATCH_RST;
         mask_r    <= predrv_pkg::MASK_RST;
         mode_r    <= predrv_pkg::MODE_RST;
         dt_r      <= predrv_pkg::DT_RST;
         sel_r     <= predrv_pkg::SEL_RST;
         ls_q_r    <= 3'h0;
         hs_q_r    <= 3'h7;
         boot_r    <= 3'h0;
         ls_seen_r <= 1'b0;
         both_q_r  <= 1'b0;
         hs_gate_r <= 3'h0;
         ls_gate_r <= 3'h0;
         hold_r    <= 1'b1;
         int_r     <= 1'b0;
         so_oe_r   <= 1'b0;
         dt_cal_r  <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         latch_r   <= latch_nxt;
         ls_q_r    <= ls_s;
         hs_q_r    <= hs_n_s;
         both_q_r  <= both_en;
         hs_gate_r <= hs_nxt;
         ls_gate_r <= ls_nxt;
         hold_r    <= 1'b0;
         int_r     <= |(latch_r & mask_r);
         so_oe_r   <= ~cs_n_s;
         dt_cal_r  <= is_dead;
         if (start) begin
            snap_r <= latch_r;
         end
         if (is_mask) begin
            if (grp_b) begin
               mask_r[7:4] <= nib;
            end else begin
               mask_r[3:0] <= nib;
            end
         end
         if (is_mode && !locked) begin
            mode_r <= {word[3], 1'b0, word[1], word[0]};
         end
         if (is_dead) begin
            dt_r <= word[4:0];
         end
         // Null picks the next reply; all other commands give status 0
         if (valid) begin
            sel_r <= is_null ? word[1:0] : predrv_pkg::SEL_RST;
         end
         ls_seen_r <= (state_r == predrv_pkg::ST_INIT) &
                      (ls_seen_r | (|ls_tog));
         boot_r    <= run ? (boot_r | ls_fall) : 3'h0;
      end
   end

   assign hs_gate_o              = hs_gate_r;
   assign ls_gate_o              = ls_gate_r;
   assign hold_off_o             = hold_r;
   assign int_o                  = int_r;
   assign so_o                   = so_bit;
   assign so_oe_o                = so_oe_r;
   assign mode_o                 = state_r;
   assign full_conduction_mode_o = mode_r[predrv_pkg::MODE_FULL_CONDUCTION_MODE];
   assign desat_ignore_o         = mode_r[predrv_pkg::MODE_DESAT];
   assign deadtime_cal_o         = dt_cal_r;
   assign deadtime_code_o        = dt_r;

   sleep_hold_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !rst_pin_s |=> hold_off_o && hs_gate_o == 3'h0 && ls_gate_o == 3'h0)
      else $error("Sleep does not hold drivers off");

   standby_off_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      state_r == predrv_pkg::ST_STANDBY ##1 state_r ==
      predrv_pkg::ST_STANDBY |-> hs_gate_o == 3'h0 && ls_gate_o == 3'h0)
      else $error("Standby gates not off");

   init_order_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $rose(state_r == predrv_pkg::ST_ENABLE) |->
      $past(state_r) == predrv_pkg::ST_INIT && $past(ls_seen_r))
      else $error("Enable reached without low-side toggle first");

   enable_stay_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      state_r == predrv_pkg::ST_ENABLE && !both_en |=>
      state_r == predrv_pkg::ST_STANDBY || state_r == predrv_pkg::ST_SLEEP)
      else $error("Enable kept after enable pin dropped");

   fault_entry_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      state_r == predrv_pkg::ST_ENABLE && flt_s[2] && both_en && !asleep
      |=> state_r == predrv_pkg::ST_FAULT ##1 hs_gate_o == 3'h0)
      else $error("Undervoltage did not force fault mode");

   sleep_clear_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !rst_pin_s |=> latch_r == 8'h00 && mask_r == 8'hff && mode_r == 4'h0)
      else $error("Sleep left registers uncleared");

   so_drive_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      so_oe_o |-> $past(!cs_n_s && rst_pin_s))
      else $error("SO driven with chip select high");

   boot_wait_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      |hs_gate_o |-> (hs_gate_o & ~$past(boot_r)) == 3'h0)
      else $error("High side on before low-side pulse");

   frame_flag_a: assert property (
      @(posedge clk_i) disable iff (rst_i || asleep)
      done && ferr |=> latch_r[predrv_pkg::FLT_FRAME] && $stable(mask_r))
      else $error("Framing error not flagged or message acted on");

   irq_level_a: assert property (
      @(posedge clk_i) disable iff (rst_i || asleep)
      (|(latch_r & mask_r)) |=> int_o)
      else $error("Interrupt dropped with enabled latch set");

   clear_keep_a: assert property (
      @(posedge clk_i) disable iff (rst_i || asleep)
      latch_r[0] && !snap_r[0] |=> latch_r[0])
      else $error("Latch set during message was cleared");

endmodule : predriver_mode_and_spi_command_ctrl

// file: hdl/predrv_pkg.sv
// Constants shared by the gate predriver control logic.
// Assumes one 125 MHz clock domain; all pin inputs are synchronised first.
package predrv_pkg;

   // Operating modes of the predriver
   typedef enum logic [2:0] {
      ST_SLEEP,
      ST_STANDBY,
      ST_INIT,
      ST_ENABLE,
      ST_FAULT
   } mode_t;

   // Serial word layout: three command bits, five data bits
   localparam int WORD_BITS = 8;
   localparam int CMD_LSB   = 5;
   localparam int GRP_BIT   = 4;

   localparam logic [2:0] CMD_NULL  = 3'h0;
   localparam logic [2:0] CMD_MASK  = 3'h1;
   localparam logic [2:0] CMD_MODE  = 3'h2;
   localparam logic [2:0] CMD_CLEAR = 3'h3;
   localparam logic [2:0] CMD_DEAD  = 3'h4;

   // Fault latch positions; low nibble is group a, high nibble group b
   localparam int FLT_OT    = 0;
   localparam int FLT_DESAT = 1;
   localparam int FLT_UV    = 2;
   localparam int FLT_OC    = 3;
   localparam int FLT_PHASE = 4;
   localparam int FLT_FRAME = 5;
   localparam int FLT_WLOCK = 6;
   localparam int FLT_RESET = 7;

   // Mode register bit positions
   localparam int MODE_LOCK   = 0;
   localparam int MODE_FULL_CONDUCTION_MODE = 1;
   localparam int MODE_DESAT  = 3;

   // Values after reset or sleep
   localparam logic [7:0] MASK_RST  = 8'hff;
   localparam logic [3:0] MODE_RST  = 4'h0;
   localparam logic [7:0] LATCH_RST = 8'h00;
   localparam logic [4:0] DT_RST    = 5'h00;
   localparam logic [1:0] SEL_RST   = 2'h0;

   // Synchroniser vector: {faults[4:0], si, sclk, cs_n, hs_n[2:0],
   // ls[2:0], en_b, en_a, rst_n}; reset values match open-pin levels
   localparam int          PIN_W   = 17;
   localparam logic [16:0] PIN_RST = 17'h003c0;

endpackage : predrv_pkg

// file: hdl/spi_shift.sv
// Serial port shifter: SI sampled on SCLK rise, SO shifts on SCLK fall.
// Assumes cs_n_i, sclk_i and si_i are already synchronised to clk_i.
module spi_shift (
   input  wire logic       clk_i,     // System clock
   input  wire logic       rst_i,     // Synchronous reset
   input  wire logic       en_i,      // Port usable (not sleeping)
   input  wire logic       cs_n_i,    // Chip select, active low
   input  wire logic       sclk_i,    // Serial clock
   input  wire logic       si_i,      // Serial data in
   input  wire logic [7:0] reply_i,   // Reply word, taken at CS fall
   output logic            start_o,   // Pulse at CS fall
   output logic            done_o,    // Pulse at CS rise
   output logic            ferr_o,    // Framing error, valid with done
   output logic [7:0]      word_o,    // Last eight bits received
   output logic            so_o       // Serial data out bit
);

   logic       cs_q_r;
   logic       sck_q_r;
   logic [7:0] rx_r;
   logic [7:0] tx_r;
   logic [2:0] cnt_r;
   logic       any_r;
   logic       start_r;
   logic       done_r;
   logic       ferr_r;

   wire cs_fall  = cs_q_r & ~cs_n_i;
   wire cs_rise  = ~cs_q_r & cs_n_i;
   wire sck_rise = ~sck_q_r & sclk_i & ~cs_n_i;
   wire sck_fall = sck_q_r & ~sclk_i & ~cs_n_i;

   always_ff @(posedge clk_i) begin
      if (rst_i || !en_i) begin
         cs_q_r  <= 1'b1;
         sck_q_r <= 1'b0;
         rx_r    <= 8'h00;
         tx_r    <= 8'h00;
         cnt_r   <= 3'h0;
         any_r   <= 1'b0;
         start_r <= 1'b0;
         done_r  <= 1'b0;
         ferr_r  <= 1'b0;
      end else begin
         cs_q_r  <= cs_n_i;
         sck_q_r <= sclk_i;
         start_r <= cs_fall;
         done_r  <= cs_rise;
         // Count wraps mod eight, so only the last eight bits count
         ferr_r  <= (cnt_r != 3'h0) | ~any_r;
         if (cs_fall) begin
            tx_r  <= reply_i;
            cnt_r <= 3'h0;
            any_r <= 1'b0;
         end
         if (sck_rise) begin
            rx_r  <= {rx_r[6:0], si_i};
            cnt_r <= cnt_r + 3'h1;
            any_r <= 1'b1;
         end
         if (sck_fall) begin
            tx_r <= {tx_r[6:0], 1'b0};
         end
      end
   end

   assign start_o = start_r;
   assign done_o  = done_r;
   assign ferr_o  = ferr_r;
   assign word_o  = rx_r;
   assign so_o    = tx_r[7];

endmodule : spi_shift

// file: sim/host_spi_model.sv
// Host microcontroller acting as SPI master: mode 0, MSB first.
// Assumes the bench calls xfer; SCLK runs only inside a frame.
module host_spi_model (
   output logic      cs_n_o,  // Chip select, low active
   output logic      sclk_o,  // Serial clock
   output logic      si_o,    // Serial data to device
   input  wire logic so_i,    // Serial data from device
   input  wire logic so_oe_i  // Device drives SO
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      si_o   = 1'b0;
   end

   // Link period 125 ns; CS stays high well over 3 clk between frames
   task automatic xfer(input int n, input logic [15:0] tx,
                       output logic [7:0] rx);
      rx = 8'h00;
      // Non-blocking: a change that falls on a clock edge lands after it
      cs_n_o <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         si_o <= tx[i];
         #62.5;
         // An undriven SO reads unknown, so a silent device never matches
         rx = {rx[6:0], so_oe_i ? so_i : 1'bx};
         sclk_o <= 1'b1;
         #62.5;
         sclk_o <= 1'b0;
      end
      #62.5;
      cs_n_o <= 1'b1;
      // Released line shows the inverse, never a stale bit
      si_o <= ~si_o;
      #100;
   endtask : xfer
endmodule : host_spi_model

// file: sim/predriver_mode_and_spi_command_ctrl_test.sv
// Self-checking bench for the predriver mode and command control.
// Assumes host_spi_model as far side; pins change on clk_i rise.
module predriver_mode_and_spi_command_ctrl_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       rst_pin_n_i = 1'b0;
   logic       en_a = 1'b0;
   logic       en_b = 1'b0;
   logic [2:0] ls = 3'h0;
   logic [2:0] hs_n = 3'h7;
   logic       uv = 1'b0;
   logic       ot = 1'b0;
   logic [7:0] n_cal = 8'h00;
   wire logic  cs_n, sclk, si;
   logic [2:0] hs_gate, ls_gate, mode;
   logic       hold_off, int_q, so, so_oe, full_on, desat_ign, dt_cal;
   logic [4:0] dt_code;
   logic [7:0] rx;
   int         n_errors = 0;
   int         comparisons = 0;

   always #4 clk_i = ~clk_i;

   predriver_mode_and_spi_command_ctrl dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .rst_pin_n_i(rst_pin_n_i),
      .enable_in_a_i(en_a), .enable_in_b_i(en_b),
      .phase_low_side_in_i(ls), .phase_high_side_in_n_i(hs_n),
      .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si),
      .overtemp_i(ot), .desat_i(1'b0), .gate_supply_uv_i(uv),
      .overcurrent_i(1'b0), .phase_err_i(1'b0),
      .hs_gate_o(hs_gate), .ls_gate_o(ls_gate), .hold_off_o(hold_off),
      .int_o(int_q), .so_o(so), .so_oe_o(so_oe), .mode_o(mode),
      .full_conduction_mode_o(full_on), .desat_ignore_o(desat_ign),
      .deadtime_cal_o(dt_cal), .deadtime_code_o(dt_code));

   host_spi_model host_u (
      .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si), .so_i(so), .so_oe_i(so_oe));

   task automatic check(input string name, input logic [7:0] seen,
                        input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Deadtime start is a one-cycle pulse; count them
   always @(posedge clk_i) begin
      if (dt_cal === 1'b1) begin
         n_cal <= n_cal + 8'h01;
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick

   task automatic frame(input int n, input logic [15:0] tx);
      host_u.xfer(n, tx, rx);
      tick(1);
   endtask : frame

   task automatic results;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results

   // 8-bit frames take about 1.2 us each; this is over ten times the whole run
   initial begin
      #500us;
      n_errors++;
      results();
   end

   initial begin
      tick(6);
      rst_i <= 1'b0;
      tick(3);
      check("mode", 8'(mode), 8'h00);
      check("hold_off", 8'(hold_off), 8'h01);
      check("int", 8'(int_q), 8'h00);
      rst_pin_n_i <= 1'b1;
      tick(10);
      check("mode", 8'(mode), 8'h01);
      check("gates", {2'b0, hs_gate, ls_gate}, 8'h00);
      check("int", 8'(int_q), 8'h01);
      check("so_oe", 8'(so_oe), 8'h00);
      frame(8, 16'h02);
      check("reply", rx, 8'h80);
      frame(8, 16'h25);
      check("reply", rx, 8'hff);
      frame(8, 16'h03);
      check("reply", rx, 8'h80);
      frame(8, 16'h02);
      check("reply", rx, 8'h00);
      frame(8, 16'h78);
      check("reply", rx, 8'hf5);
      check("int", 8'(int_q), 8'h00);
      frame(7, 16'h00);
      check("int", 8'(int_q), 8'h01);
      frame(8, 16'h00);
      check("reply", rx, 8'h20);
      frame(8, 16'h72);
      check("int", 8'(int_q), 8'h00);
      frame(16, 16'hff84);
      check("dt_code", 8'(dt_code), 8'h04);
      check("dt_cal", n_cal, 8'h01);
      for (int c = 5; c < 8; c++) begin
         frame(8, {8'h00, 3'(c), 5'h1f});
         check("reply", rx, 8'h00);
         check("dt_code", 8'(dt_code), 8'h04);
      end
      frame(8, 16'h02);
      frame(8, 16'h00);
      check("mask", rx, 8'hf5);
      check("dt_cal", n_cal, 8'h01);
      frame(8, 16'h48);
      check("desat_ign", 8'(desat_ign), 8'h01);
      frame(8, 16'h43);
      check("full_on", 8'(full_on), 8'h01);
      frame(8, 16'h48);
      check("desat_ign", 8'(desat_ign), 8'h00);
      check("int", 8'(int_q), 8'h01);
      frame(8, 16'h74);
      // Overtemp rises mid-message, after the snapshot: clear must miss it
      fork
         frame(8, 16'h61);
         begin
            tick(40);
            ot <= 1'b1;
            tick(10);
            ot <= 1'b0;
         end
      join
      check("reply", rx, 8'h00);
      check("int", 8'(int_q), 8'h01);
      frame(8, 16'h00);
      check("reply", rx, 8'h01);
      frame(8, 16'h61);
      check("int", 8'(int_q), 8'h00);
      en_a <= 1'b1;
      en_b <= 1'b1;
      tick(10);
      check("mode", 8'(mode), 8'h02);
      ls <= 3'h1;
      tick(10);
      ls <= 3'h0;
      tick(10);
      hs_n <= 3'h6;
      tick(10);
      hs_n <= 3'h7;
      tick(10);
      check("mode", 8'(mode), 8'h03);
      ls <= 3'h4;
      tick(10);
      check("ls_gate", 8'(ls_gate), 8'h04);
      ls <= 3'h0;
      hs_n <= 3'h4;
      tick(10);
      check("hs_gate", 8'(hs_gate), 8'h01);
      hs_n <= 3'h7;
      uv <= 1'b1;
      tick(10);
      check("mode", 8'(mode), 8'h04);
      check("gates", {2'b0, hs_gate, ls_gate}, 8'h00);
      uv <= 1'b0;
      tick(10);
      check("mode", 8'(mode), 8'h02);
      en_a <= 1'b0;
      tick(10);
      check("mode", 8'(mode), 8'h01);
      en_a <= 1'b1;
      rst_pin_n_i <= 1'b0;
      tick(10);
      check("mode", 8'(mode), 8'h00);
      check("hold_off", 8'(hold_off), 8'h01);
      check("int", 8'(int_q), 8'h00);
      check("regs", {2'b0, full_on, dt_code}, 8'h00);
      results();
   end
endmodule : predriver_mode_and_spi_command_ctrl_test
